// *** hw/host_serial_port.sv ***
// asynchronous serial port facing the host: tx engine, rx engine with fifo
// assumes settings are only loaded while both lines are idle
`timescale 1ns/10ps
module host_serial_port
  import serial_port_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // host-side pins
  output logic uart_tx,
  input wire logic uart_rx,
  output logic rts_n,
  input wire logic cts_n,
  // configuration
  input wire logic cfg_load,
  input wire logic [serial_port_pkg::DIV_W-1:0] cfg_divisor,
  input wire logic cfg_flow,
  input wire logic [1:0] cfg_parity,
  input wire logic cfg_stop2,
  input wire logic cfg_assist,
  // transmit stream from the module core
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // receive stream toward the module core
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  output logic rx_frame_end,
  // status
  output logic rx_parity_err,
  output logic rx_framing_err,
  output logic rx_overrun
);
  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} bit_state_e;

  logic [DIV_W-1:0] div_ff;
  logic flow_ff;
  logic [1:0] par_ff;
  logic stop2_ff;
  logic assist_ff;

  // settings: reset gives the power-up format; loads are not gated, so the user
  // must only pulse cfg_load while both lines are idle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      div_ff <= DIV_DEFAULT; // [R9]
      flow_ff <= FLOW_DEFAULT; // [R9]
      par_ff <= PARITY_DEFAULT; // [R9]
      stop2_ff <= STOP2_DEFAULT; // [R9]
      assist_ff <= ASSIST_DEFAULT;
    end else if (cfg_load) begin
      // clamp keeps the rate inside the supported range [R3]
      div_ff <= (cfg_divisor < DIV_MIN) ? DIV_MIN :
                (cfg_divisor > DIV_MAX) ? DIV_MAX : cfg_divisor;
      flow_ff <= cfg_flow; // [R4]
      par_ff <= (cfg_parity == 2'h3) ? PAR_NONE : cfg_parity; // [R6]
      stop2_ff <= cfg_stop2; // [R7]
      assist_ff <= cfg_assist; // [R8]
    end
  end

  // pin input synchronisers; a change counts once stages two and three agree
  logic [2:0] rx_sync_ff;
  logic [2:0] cts_sync_ff;
  logic rx_ff;
  logic cts_n_ff;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_sync_ff <= 3'h7;
      cts_sync_ff <= 3'h7;
      rx_ff <= 1'b1;
      cts_n_ff <= 1'b1;
    end else begin
      rx_sync_ff <= {rx_sync_ff[1:0], uart_rx};
      cts_sync_ff <= {cts_sync_ff[1:0], cts_n};
      if (rx_sync_ff[1] == rx_sync_ff[2]) begin
        rx_ff <= rx_sync_ff[2];
      end
      if (cts_sync_ff[1] == cts_sync_ff[2]) begin
        cts_n_ff <= cts_sync_ff[2];
      end
    end
  end

  // transmitter
  bit_state_e tx_st_ff;
  logic [DIV_W-1:0] tx_cnt_ff;
  logic [2:0] tx_bit_ff;
  logic [7:0] tx_sh_ff;
  logic tx_par_ff;
  logic tx_stop_ff;
  logic tx_ready_ff;
  logic tx_tick;
  logic tx_go;
  assign tx_tick = (tx_cnt_ff == '0);
  // a character only starts with cts low when handshake is on [R10]
  assign tx_go = tx_valid && tx_ready_ff && !(flow_ff && cts_n_ff);
  assign tx_ready = tx_ready_ff;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_st_ff <= S_IDLE;
      tx_cnt_ff <= '0;
      tx_bit_ff <= '0;
      tx_sh_ff <= '0;
      tx_par_ff <= 1'b0;
      tx_stop_ff <= 1'b0;
      tx_ready_ff <= 1'b0;
      uart_tx <= 1'b1; // line idles high [R11]
    end else begin
      tx_ready_ff <= 1'b0;
      tx_cnt_ff <= tx_tick ? div_ff - 1'b1 : tx_cnt_ff - 1'b1;
      unique case (tx_st_ff)
        S_IDLE: begin
          uart_tx <= 1'b1;
          tx_ready_ff <= !tx_go;
          if (tx_go) begin
            tx_sh_ff <= tx_data; // [R5]
            tx_par_ff <= (par_ff == PAR_ODD) ^ (^tx_data); // [R6]
            uart_tx <= 1'b0; // start bit [R1] [R11]
            tx_cnt_ff <= div_ff - 1'b1;
            tx_st_ff <= S_START;
          end
        end
        S_START: if (tx_tick) begin
          uart_tx <= tx_sh_ff[0]; // lsb first [R11]
          tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
          tx_bit_ff <= '0;
          tx_st_ff <= S_DATA;
        end
        S_DATA: if (tx_tick) begin
          tx_bit_ff <= tx_bit_ff + 1'b1;
          if (tx_bit_ff == 3'(DATA_BITS - 1)) begin
            tx_stop_ff <= stop2_ff; // [R7]
            if (par_ff != PAR_NONE) begin
              uart_tx <= tx_par_ff;
              tx_st_ff <= S_PAR;
            end else begin
              uart_tx <= 1'b1;
              tx_st_ff <= S_STOP;
            end
          end else begin
            uart_tx <= tx_sh_ff[0];
            tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
          end
        end
        S_PAR: if (tx_tick) begin
          uart_tx <= 1'b1;
          tx_st_ff <= S_STOP;
        end
        S_STOP: if (tx_tick) begin
          // second stop bit when configured [R7]
          if (tx_stop_ff) begin
            tx_stop_ff <= 1'b0;
          end else begin
            tx_st_ff <= S_IDLE;
          end
        end
        default: tx_st_ff <= S_IDLE;
      endcase
    end
  end

  // receiver: samples each bit at its middle
  bit_state_e rx_st_ff;
  logic [DIV_W-1:0] rx_cnt_ff;
  logic [2:0] rx_bit_ff;
  logic [7:0] rx_sh_ff;
  logic rx_par_ff;
  logic rx_push_ff;
  logic [7:0] rx_byte_ff;
  logic fifo_in_ready;
  logic [3:0] fifo_level;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_st_ff <= S_IDLE;
      rx_cnt_ff <= '0;
      rx_bit_ff <= '0;
      rx_sh_ff <= '0;
      rx_par_ff <= 1'b0;
      rx_push_ff <= 1'b0;
      rx_byte_ff <= '0;
      rx_parity_err <= 1'b0;
      rx_framing_err <= 1'b0;
      rx_overrun <= 1'b0;
    end else begin
      rx_push_ff <= 1'b0;
      rx_parity_err <= 1'b0;
      rx_framing_err <= 1'b0;
      rx_overrun <= 1'b0;
      rx_cnt_ff <= (rx_cnt_ff == '0) ? div_ff - 1'b1 : rx_cnt_ff - 1'b1;
      unique case (rx_st_ff)
        S_IDLE: if (!rx_ff) begin
          rx_cnt_ff <= {1'b0, div_ff[DIV_W-1:1]}; // half bit to centre
          rx_st_ff <= S_START;
        end
        S_START: if (rx_cnt_ff == '0) begin
          // a glitch shorter than half a bit is not a start [R11]
          rx_st_ff <= rx_ff ? S_IDLE : S_DATA;
          rx_bit_ff <= '0;
          rx_par_ff <= (par_ff == PAR_ODD);
        end
        S_DATA: if (rx_cnt_ff == '0) begin
          rx_sh_ff <= {rx_ff, rx_sh_ff[7:1]}; // lsb first [R5] [R11]
          rx_par_ff <= rx_par_ff ^ rx_ff;
          rx_bit_ff <= rx_bit_ff + 1'b1;
          if (rx_bit_ff == 3'(DATA_BITS - 1)) begin
            rx_st_ff <= (par_ff != PAR_NONE) ? S_PAR : S_STOP;
          end
        end
        S_PAR: if (rx_cnt_ff == '0) begin
          rx_parity_err <= rx_par_ff ^ rx_ff; // [R6]
          rx_st_ff <= S_STOP;
        end
        S_STOP: if (rx_cnt_ff == '0) begin
          // one stop bit is checked; a second one looks like idle to us
          rx_framing_err <= !rx_ff;
          rx_byte_ff <= rx_sh_ff;
          rx_push_ff <= rx_ff;
          rx_overrun <= rx_ff && !fifo_in_ready; // host ignored rts
          rx_st_ff <= S_IDLE;
        end
        default: rx_st_ff <= S_IDLE;
      endcase
    end
  end

  // receive fifo: the core can stall, rts then tells the host to stop
  logic f_valid;
  logic [7:0] f_data;
  logic f_ready;
  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rx_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_valid(rx_push_ff),
    .in_ready(fifo_in_ready),
    .in_data(rx_byte_ff),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data),
    .level(fifo_level)
  );

  // rts low only while two or more slots remain, since one byte may be in flight
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rts_n <= 1'b1;
    end else begin
      rts_n <= !(flow_ff && (fifo_level <= 4'(FIFO_DEPTH - 2))); // [R2] [R4] [R10]
    end
  end

  // output stage; with framing assist an end byte is flagged, not passed on
  assign f_ready = !rx_valid || rx_ready;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_valid <= 1'b0;
      rx_data <= '0;
      rx_frame_end <= 1'b0;
    end else begin
      rx_frame_end <= 1'b0;
      if (f_ready) begin
        rx_valid <= 1'b0;
        if (f_valid) begin
          if (assist_ff && (f_data == SLIP_END)) begin
            rx_frame_end <= 1'b1; // [R8]
          end else begin
            rx_valid <= 1'b1;
            rx_data <= f_data;
          end
        end
      end
    end
  end
endmodule

// *** hw/serial_port_pkg.sv ***
// package of constants for the host serial port
// assumes a single 25 MHz clock and a synchronous active-high reset
// Summary of operation
// R1: the block drives the transmit line to the host and samples the receive line from the host.
// R2: request-to-send is a block output and clear-to-send a host input, both active low.
// R3: the bit rate is selectable from 1200 to 921600 bits per second, same at both ends.
// R4: flow control is either the rts/cts handshake or none.
// R5: every character has exactly eight data bits.
// R6: parity is none, odd or even.
// R7: each character ends with one or two stop bits.
// R8: a switchable framing-assist option for a serial link protocol is provided.
// R9: after reset the port runs 115200 baud, no flow control, 8 bits, no parity, one stop bit.
// R10: with handshake on, no character starts while cts is high, and rts is low only while space remains.
// R11: a character is a low start bit, data lsb first, optional parity, high stop bits; idle high.
package serial_port_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned BAUD_MIN = 1200;
  localparam int unsigned BAUD_MAX = 921600;
  localparam int unsigned BAUD_DEFAULT = 115200;
  // divisor is clock cycles per bit; 16 bits cover 1200 baud (20833)
  localparam int unsigned DIV_W = 16;
  localparam logic [15:0] DIV_DEFAULT = 16'(CLK_HZ / BAUD_DEFAULT);
  localparam logic [15:0] DIV_MIN = 16'(CLK_HZ / BAUD_MAX);
  localparam logic [15:0] DIV_MAX = 16'(CLK_HZ / BAUD_MIN);
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  // slip end byte used by the framing assist
  localparam logic [7:0] SLIP_END = 8'hc0;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PARITY_DEFAULT = PAR_NONE;
  localparam logic FLOW_DEFAULT = 1'b0;
  localparam logic STOP2_DEFAULT = 1'b0;
  localparam logic ASSIST_DEFAULT = 1'b0;
endpackage

// *** hw/byte_fifo.sv ***
// small synchronous fifo with valid/ready on both sides
// assumes one clock and synchronous active-high reset
`timescale 1ns/10ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // fill level for watermarks
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic [WIDTH-1:0] dout_ff;
  logic dval_ff;
  logic push;
  logic pop;
  logic load;

  // output register is a one-word skid stage fed from memory
  assign push = in_valid && in_ready;
  assign load = (cnt_ff != '0) && (!dval_ff || out_ready);
  assign pop = load;
  assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = dval_ff;
  assign out_data = dout_ff;
  assign level = cnt_ff;

  // storage writes
  always_ff @(posedge clock) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // registered read data
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dval_ff <= 1'b0;
      dout_ff <= '0;
    end else if (load) begin
      dval_ff <= 1'b1;
      dout_ff <= mem_ff[rd_ff];
    end else if (out_ready) begin
      dval_ff <= 1'b0;
    end
  end
endmodule

// *** sim/serial_port_chk.sv ***
// pin and stream checks for the host serial port
// assumes bind onto host_serial_port; loaded settings shadowed here
`timescale 1ns/10ps
module serial_port_chk (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // pins, settings, streams
  input wire logic uart_tx,
  input wire logic rts_n,
  input wire logic cts_n,
  input wire logic cfg_load,
  input wire logic cfg_flow,
  input wire logic cfg_assist,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic rx_frame_end,
  input wire logic rx_overrun
);
  logic flow_ff;
  logic assist_ff;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // live cfg inputs may differ from what was loaded
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      flow_ff <= 1'b0;
      assist_ff <= 1'b0;
    end else if (cfg_load) begin
      flow_ff <= cfg_flow;
      assist_ff <= cfg_assist;
    end
  end
  sequence s_take; tx_valid && tx_ready && !flow_ff; endsequence
  sequence s_held; (flow_ff && cts_n && tx_ready)[*5]; endsequence
  property p_rst; $fell(sys_rst) |-> uart_tx && rts_n && !rx_valid; endproperty
  property p_take; s_take |=> !uart_tx && !tx_ready; endproperty
  property p_bit; $fell(uart_tx) |-> !uart_tx[*8]; endproperty
  property p_idle; tx_ready |-> uart_tx; endproperty
  property p_held; s_held |=> uart_tx; endproperty
  property p_noflow; (!flow_ff)[*2] |-> rts_n; endproperty
  property p_full; flow_ff && rx_overrun |-> rts_n; endproperty
  property p_hold; rx_valid && !rx_ready |=> rx_valid && $stable(rx_data); endproperty
  property p_fend; rx_frame_end |-> assist_ff; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  a_take: assert property (p_take) else $error("start bit late");
  a_bit: assert property (p_bit) else $error("bit too short");
  a_idle: assert property (p_idle) else $error("idle line low");
  a_held: assert property (p_held) else $error("start while held");
  a_noflow: assert property (p_noflow) else $error("rts without flow");
  a_full: assert property (p_full) else $error("rts low when full");
  a_hold: assert property (p_hold) else $error("rx data moved");
  a_fend: assert property (p_fend) else $error("frame end unasked");
endmodule
bind host_serial_port serial_port_chk chk (.clock, .sys_rst, .uart_tx, .rts_n, .cts_n,
  .cfg_load, .cfg_flow, .cfg_assist, .tx_valid, .tx_ready, .rx_valid, .rx_data,
  .rx_ready, .rx_frame_end, .rx_overrun);

// *** sim/host_model.sv ***
// host side of the serial link: drives rx, decodes tx, owns cts
// assumes the bench hands over the bit time in clock cycles
`timescale 1ns/10ps
module host_model (
  // clock
  input wire logic clock,
  // serial lines
  input wire logic uart_tx,
  output logic uart_rx,
  input wire logic rts_n,
  output logic cts_n
);
  logic hold_off = 1'b0;
  assign cts_n = hold_off;  // low lets the block start
  initial uart_rx = 1'b1;  // pulled-up line idles high
  // one bit time, ending just after an edge
  task automatic put(input logic b, input int n);
    uart_rx = b;
    repeat (n) @(posedge clock);
    #2;
  endtask
  // start, data lsb first, parity, stop; bad flips parity or stop
  task automatic send(input logic [7:0] d, input logic [1:0] p, input int n,
                      input logic fc, input logic [1:0] bad);
    while (fc && rts_n) @(posedge clock);  // wait for room
    @(posedge clock) #2;
    put(1'b0, n);
    for (int i = 0; i < 8; i++) put(d[i], n);
    if (p != 2'h0) put((p == 2'h1) ^ (^d) ^ bad[0], n);
    put(~bad[1], n);
    put(1'b1, n);
  endtask
  // eleven samples taken mid-bit from the start edge
  task automatic recv(input int n, output logic [10:0] f);
    @(negedge uart_tx);
    repeat (n / 2) @(posedge clock);
    for (int i = 0; i < 11; i++) begin
      f[i] = uart_tx;
      repeat (n) @(posedge clock);
    end
  endtask
endmodule

// *** sim/host_serial_port_bench.sv ***
// self-checking bench for the host serial port against a host model
// assumes package, fifo, port, checker and model compiled first
`timescale 1ns/10ps
module host_serial_port_bench;
  import serial_port_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic uart_tx, uart_rx, rts_n, cts_n, tx_ready, rx_valid, rx_frame_end;
  logic rx_parity_err, rx_framing_err, rx_overrun;
  logic cfg_load = 1'b0, cfg_flow = 1'b0, cfg_stop2 = 1'b0, cfg_assist = 1'b0;
  logic [1:0] cfg_parity = 2'h0;
  logic [15:0] cfg_divisor = 16'h00d9;
  logic tx_valid = 1'b0, rx_ready = 1'b0;
  logic [7:0] tx_data = 8'h00, rx_data;
  int n_errors = 0, n_checks = 0, n_pe = 0, n_fe = 0, n_ov = 0, n_fr = 0;
  int div = 217;
  always #20 clock = ~clock;
  host_serial_port dut (.*);
  host_model host (.*);
  // pulses are tallied so scenarios can compare counts
  always @(posedge clock) begin
    if (rx_parity_err === 1'b1) n_pe++;
    if (rx_framing_err === 1'b1) n_fe++;
    if (rx_overrun === 1'b1) n_ov++;
    if (rx_frame_end === 1'b1) n_fr++;
  end
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clock) #2;
    sys_rst = 1'b1;
    repeat (8) @(posedge clock);
    #2;
    sys_rst = 1'b0;
    div = 217;
    repeat (2) @(posedge clock);
    #2;
  endtask
  task automatic setup(input int d, input logic fl, input logic [1:0] p, input logic s2,
                       input logic as);
    {cfg_flow, cfg_parity, cfg_stop2, cfg_assist} = {fl, p, s2, as};
    cfg_divisor = 16'(d);
    div = d;
    cfg_load = 1'b1;
    @(posedge clock) #2;
    cfg_load = 1'b0;
    @(posedge clock) #2;
  endtask
  // valid held until taken; frame seen by the host, length by tx_ready
  task automatic tx_byte(input logic [7:0] d, input logic [1:0] p, input logic s2);
    logic [10:0] f;
    int n;
    int nb;
    nb = 10 + int'(p != 2'h0) + int'(s2);
    fork
      host.recv(div, f);
      begin
        while (tx_ready !== 1'b1) @(posedge clock) #2;
        tx_data = d;
        tx_valid = 1'b1;
        do @(posedge clock) #2; while (tx_ready === 1'b1);
        tx_valid = 1'b0;
        n = 0;
        for (n = 0; tx_ready !== 1'b1; n++) @(posedge clock) #2;
      end
    join
    chk("tx length", 1'b1, 16'(n >= nb * div - 1 && n <= nb * div + 2));
    chk("tx frame", {1'b1, p == 2'h0 || ((p == 2'h1) ^ (^d)), d, 1'b0}, f);
  endtask
  task automatic pop(input logic [7:0] d);
    for (int k = 0; k < 100 && rx_valid !== 1'b1; k++) @(posedge clock) #2;
    chk("rx data", d, rx_data);
    rx_ready = 1'b1;
    @(posedge clock) #2;
    rx_ready = 1'b0;
  endtask
  task automatic t_default();
    chk("idle line", 1'b1, uart_tx);
    chk("rts idle", 1'b1, rts_n);
    tx_byte(8'ha5, PAR_NONE, 1'b0);
    host.send(8'h3c, PAR_NONE, div, 1'b0, 2'h0);
    pop(8'h3c);
    // out-of-range divisor clamps to the fastest rate, parity code 3 means none
    setup(5, 1'b0, 2'h3, 1'b0, 1'b0);
    div = int'(DIV_MIN);
    tx_byte(8'h5a, PAR_NONE, 1'b0);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 6; m++) begin
      setup(27, 1'b0, 2'(m / 2), 1'(m), 1'b0);
      tx_byte(8'h17 ^ 8'(m * 37), 2'(m / 2), 1'(m));
      host.send(8'he8 ^ 8'(m * 9), 2'(m / 2), div, 1'b0, 2'h0);
      pop(8'he8 ^ 8'(m * 9));
    end
    chk("parity flags", 16'h0, 16'(n_pe));
  endtask
  task automatic t_errors();
    host.send(8'h81, PAR_EVEN, div, 1'b0, 2'h1);
    chk("parity error", 16'h1, 16'(n_pe));
    host.send(8'h42, PAR_EVEN, div, 1'b0, 2'h2);
    chk("framing error", 16'h1, 16'(n_fe));
  endtask
  task automatic t_flow();
    host.hold_off = 1'b1;
    setup(27, 1'b1, PAR_NONE, 1'b0, 1'b0);
    chk("rts ready", 1'b0, rts_n);
    // let the raised cts pass the synchroniser before offering a byte
    repeat (4) @(posedge clock);
    #2;
    fork
      tx_byte(8'hc3, PAR_NONE, 1'b0);
      begin
        repeat (200) @(posedge clock);
        #2;
        chk("tx held", 1'b1, uart_tx);
        host.hold_off = 1'b0;
      end
    join
    // ten bytes fill fifo and output stages; the eleventh must overrun
    for (int i = 0; i < 11; i++) host.send(8'(16 + i), PAR_NONE, div, 1'b0, 2'h0);
    chk("rts full", 1'b1, rts_n);
    chk("overrun", 16'h1, 16'(n_ov != 0));
    for (int i = 0; i < 10; i++) pop(8'(16 + i));
    chk("rts drained", 1'b0, rts_n);
    host.send(8'h99, PAR_NONE, div, 1'b1, 2'h0);
    pop(8'h99);
  endtask
  task automatic t_assist();
    setup(27, 1'b0, PAR_NONE, 1'b0, 1'b1);
    host.send(SLIP_END, PAR_NONE, div, 1'b0, 2'h0);
    chk("frame end", 16'h1, 16'(n_fr));
    chk("marker dropped", 1'b0, rx_valid);
  endtask
  initial begin
    #3000000;
    n_errors++;
    wrap_up();
  end
  initial begin
    do_reset();
    t_default();
    t_modes();
    t_errors();
    do_reset();
    t_flow();
    do_reset();
    t_assist();
    wrap_up();
  end
endmodule
